/* File: src/fsps_sequencer.sv */
// Flash self-programming sequencer: control register, timing, address map.
`timescale 1ns/1ps
`default_nettype none
module fsps_sequencer
  import fsps_pkg::*;
#(
  parameter int unsigned PROG_TICKS = PROG_TICKS_DEF
)
(
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  input wire logic i_rc_clk,
  input wire logic i_boot_size_sel_hi,
  input wire logic i_boot_size_sel_lo,
  input wire logic i_eeprom_write_busy_bit,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic i_spm_exec,
  input wire logic [15:0] i_spm_data,
  input wire logic [PC_W-1:0] i_fetch_addr,
  output logic o_fetch_allow,
  output logic o_cpu_halt,
  output logic o_prog_req,
  output logic o_erase_req,
  output logic o_write_req,
  output logic o_lock_req,
  output logic o_fill_req,
  output logic [15:0] o_fill_data,
  output logic [7:0] o_lock_data,
  output fsps_addr_s o_flash_addr,
  output fsps_boot_s o_boot
);

  ////////////////////////////////////////////////////////////////////////
  // Decode helpers.

  // Word address lies in the region that cannot be fetched during an erase or write.
  function automatic logic is_readable(input logic [PC_W-1:0] a);
    is_readable = (a <= READABLE_LAST);
  endfunction : is_readable

  // Map the 16-bit pointer onto page, word and byte selects.
  function automatic fsps_addr_s split_ptr(input logic [PTR_W-1:0] p);
    fsps_addr_s r;
    r.page_select_field = p[13:7];
    r.word_select_field = p[6:1];
    r.byte_sel = p[0];
    // Bits 15 and 14 never reach the flash.
    split_ptr = r;
  endfunction : split_ptr

  // Flash word address formed by page and word fields.
  function automatic logic [PC_W-1:0] word_addr(input fsps_addr_s a);
    word_addr = {a.page_select_field, a.word_select_field};
  endfunction : word_addr

  ////////////////////////////////////////////////////////////////////////
  // Registers.
  fsps_state_e state;
  fsps_state_e next_state;
  logic [6:0] cmd;
  logic busy;
  logic [PTR_W-1:0] ptr;
  logic [1:0] win_cnt;
  logic boot_hi;
  logic boot_lo;
  logic in_blocked;
  logic strap_taken;
  logic ee_s1;
  logic ee_s2;
  logic timer_done;

  ////////////////////////////////////////////////////////////////////////
  // Strap and pin capture.

  // Fuses are caught by a clock edge after reset, never by the reset.
  always_ff @(posedge i_clk_sys or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      strap_taken <= 1'b0;
      boot_hi <= 1'b1;
      boot_lo <= 1'b1;
    end
    else if (!strap_taken)
    begin
      strap_taken <= 1'b1;
      boot_hi <= i_boot_size_sel_hi;
      boot_lo <= i_boot_size_sel_lo;
    end
  end

  // EEPROM busy comes from another block's timing, so synchronise it.
  always_ff @(posedge i_clk_sys or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      ee_s1 <= 1'b0;
      ee_s2 <= 1'b0;
    end
    else
    begin
      ee_s1 <= i_eeprom_write_busy_bit;
      ee_s2 <= ee_s1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Boot section layout from the fuse pair.
  wire [1:0] boot_sel = {boot_hi, boot_lo};
  wire [PC_W-1:0] boot_start =
    (boot_sel == 2'h3) ? BOOT_START_128 :
    (boot_sel == 2'h2) ? BOOT_START_256 :
    (boot_sel == 2'h1) ? BOOT_START_512 :
    BOOT_START_1K;
  wire [PC_W-1:0] app_end =
    (boot_sel == 2'h3) ? APP_END_128 :
    (boot_sel == 2'h2) ? APP_END_256 :
    (boot_sel == 2'h1) ? APP_END_512 :
    APP_END_1K;

  ////////////////////////////////////////////////////////////////////////
  // Register port decode.
  wire wr_ctrl = i_wr && (i_addr == OFS_CTRL);
  wire wr_ptr_lo = i_wr && (i_addr == OFS_PTR_LO);
  wire wr_ptr_hi = i_wr && (i_addr == OFS_PTR_HI);
  // A command write is refused while an operation runs or EEPROM writes.
  wire cmd_ok = (state == FSPS_IDLE) && !ee_s2;
  wire [6:0] wcmd = i_wdata[6:0] & CMD_MASK;
  wire take_cmd = wr_ctrl && cmd_ok && wcmd[BIT_ENABLE];
  wire is_reen = (cmd == CMD_REEN);
  wire is_timed = (cmd == CMD_ERASE) || (cmd == CMD_WRITE) ||
    (cmd == CMD_LOCK);
  wire fire = (state == FSPS_ARMED) && i_spm_exec;
  wire win_over = (state == FSPS_ARMED) && !i_spm_exec &&
    (win_cnt == 2'(CMD_WINDOW_CYC - 1));
  wire fsps_addr_s addr_split = split_ptr(ptr);
  wire fire_timed = fire && is_timed;
  wire fire_reen = fire && is_reen;

  // Next state of the command sequence.
  always_comb
  begin
    next_state = state;
    case (state)
      FSPS_IDLE:
        if (take_cmd)
          next_state = FSPS_ARMED;
      FSPS_ARMED:
        if (fire_timed)
          next_state = FSPS_PROG;
        else if (fire || win_over)
          next_state = FSPS_IDLE;
      FSPS_PROG:
        if (timer_done)
          next_state = FSPS_DONE;
      FSPS_DONE:
        next_state = FSPS_IDLE;
      default:
        next_state = FSPS_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // State, command and window counter.
  always_ff @(posedge i_clk_sys or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      state <= FSPS_IDLE;
      cmd <= '0;
      win_cnt <= '0;
    end
    else
    begin
      state <= next_state;
      if (take_cmd)
        cmd <= wcmd;
      else if (next_state == FSPS_IDLE && state != FSPS_IDLE)
        cmd <= '0;
      if (state == FSPS_ARMED)
        win_cnt <= win_cnt + 2'h1;
      else
        win_cnt <= '0;
    end
  end

  // Pointer register, written a byte at a time.
  always_ff @(posedge i_clk_sys or negedge i_rstn)
  begin
    if (!i_rstn)
      ptr <= '0;
    else if (wr_ptr_lo)
      ptr[7:0] <= i_wdata;
    else if (wr_ptr_hi)
      ptr[15:8] <= i_wdata;
  end

  // Busy: set on starting erase or write of the readable region, cleared
  // only by the re-enable command, and never while an operation runs.
  wire busy_set = fire && ((cmd == CMD_ERASE) || (cmd == CMD_WRITE)) &&
    is_readable(word_addr(addr_split));
  always_ff @(posedge i_clk_sys or negedge i_rstn)
  begin
    if (!i_rstn)
      busy <= 1'b0;
    else if (busy_set)
      busy <= 1'b1;
    else if (fire_reen)
      busy <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // The programming timer counted on the RC oscillator.
  fsps_rc_timer #(
    .TICKS(PROG_TICKS)
  ) u_timer (
    .i_clk_sys(i_clk_sys),
    .i_rstn(i_rstn),
    .i_rc_clk(i_rc_clk),
    .i_start(fire_timed),
    .o_done(timer_done)
  );

  ////////////////////////////////////////////////////////////////////////
  // Requests to the flash array, registered so data outputs are clean.
  always_ff @(posedge i_clk_sys or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_erase_req <= 1'b0;
      o_write_req <= 1'b0;
      o_lock_req <= 1'b0;
      o_fill_req <= 1'b0;
      o_fill_data <= '0;
      o_lock_data <= '0;
      o_flash_addr <= '0;
      in_blocked <= 1'b0;
    end
    else
    begin
      o_erase_req <= fire && (cmd == CMD_ERASE);
      o_write_req <= fire && (cmd == CMD_WRITE);
      o_lock_req <= fire && (cmd == CMD_LOCK);
      o_fill_req <= fire && (cmd == CMD_FILL);
      if (fire && (cmd == CMD_FILL))
        o_fill_data <= i_spm_data;
      if (fire && (cmd == CMD_LOCK))
        o_lock_data <= i_spm_data[7:0];
      o_flash_addr <= addr_split;
      if (fire_timed)
        in_blocked <= !is_readable(word_addr(addr_split)) &&
          (cmd != CMD_LOCK);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Fetch gate and halt; a lock write leaves all of flash readable.
  wire erase_or_write = (state == FSPS_PROG) && (cmd != CMD_LOCK);
  assign o_prog_req = (state == FSPS_PROG);
  assign o_fetch_allow = !erase_or_write ||
    (!is_readable(i_fetch_addr) && !in_blocked);
  assign o_cpu_halt = erase_or_write && in_blocked;
  assign o_boot.boot_start = boot_start;
  assign o_boot.app_end = app_end;

  ////////////////////////////////////////////////////////////////////////
  // Read data, one cycle after the read strobe; unmapped reads give zero.
  wire [7:0] ctrl_view = {1'b0, busy, cmd[5:0]};
  // Bit 1 follows the halt, so a finished blocked-region job never lingers.
  wire [7:0] stat_view = {5'h00, ee_s2, o_cpu_halt, o_prog_req};
  wire [7:0] rd_mux =
    (i_addr == OFS_CTRL) ? ctrl_view :
    (i_addr == OFS_PTR_LO) ? ptr[7:0] :
    (i_addr == OFS_PTR_HI) ? ptr[15:8] :
    (i_addr == OFS_STATUS) ? stat_view :
    (i_addr == OFS_SEL) ? {6'h00, boot_sel} :
    8'h00;
  always_ff @(posedge i_clk_sys or negedge i_rstn)
  begin
    if (!i_rstn)
      o_rdata <= '0;
    else if (i_rd)
      o_rdata <= rd_mux;
    else
      o_rdata <= '0;
  end

endmodule : fsps_sequencer
`default_nettype wire

/* File: common/fsps_pkg.sv */
// Package for the flash self-programming sequencer: constants, types, map.
package fsps_pkg;

  // Clock and timing.
  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned RC_HZ = 8000000;
  localparam int unsigned PROG_MIN_US = 3700;
  localparam int unsigned PROG_MAX_US = 4500;
  // Programming time in RC ticks, halfway between the least and longest time.
  localparam int unsigned PROG_TICKS_DEF =
    ((PROG_MIN_US + PROG_MAX_US) / 2) * (RC_HZ / 1000000);
  localparam int unsigned CMD_WINDOW_CYC = 4;

  // Flash geometry.
  localparam int unsigned PC_W = 13;
  localparam int unsigned WORD_SEL_W = 6;
  localparam int unsigned PAGE_SEL_W = 7;
  localparam int unsigned PTR_W = 16;
  localparam logic [PC_W-1:0] READABLE_LAST = 13'h1BFF;
  localparam logic [PC_W-1:0] BLOCKED_FIRST = 13'h1C00;
  localparam logic [PC_W-1:0] BOOT_START_128 = 13'h1F80;
  localparam logic [PC_W-1:0] BOOT_START_256 = 13'h1F00;
  localparam logic [PC_W-1:0] BOOT_START_512 = 13'h1E00;
  localparam logic [PC_W-1:0] BOOT_START_1K = 13'h1C00;
  localparam logic [PC_W-1:0] APP_END_128 = 13'h1F7F;
  localparam logic [PC_W-1:0] APP_END_256 = 13'h1EFF;
  localparam logic [PC_W-1:0] APP_END_512 = 13'h1DFF;
  localparam logic [PC_W-1:0] APP_END_1K = 13'h1BFF;

  // Control register bit positions.
  localparam int unsigned BIT_ENABLE = 0;
  localparam int unsigned BIT_ERASE = 1;
  localparam int unsigned BIT_WRITE = 2;
  localparam int unsigned BIT_LOCK = 3;
  localparam int unsigned BIT_REEN = 4;
  localparam int unsigned BIT_BUSY = 6;
  localparam logic [6:0] CMD_MASK = 7'h7F;
  localparam logic [6:0] CMD_FILL = 7'h01;
  localparam logic [6:0] CMD_ERASE = 7'h03;
  localparam logic [6:0] CMD_WRITE = 7'h05;
  localparam logic [6:0] CMD_LOCK = 7'h09;
  localparam logic [6:0] CMD_REEN = 7'h11;

  // Register offsets on the plain port.
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_PTR_LO = 4'h1;
  localparam logic [3:0] OFS_PTR_HI = 4'h2;
  localparam logic [3:0] OFS_STATUS = 4'h3;
  localparam logic [3:0] OFS_SEL = 4'h4;

  typedef enum logic [2:0] {
    FSPS_IDLE = 3'b000,
    FSPS_ARMED = 3'b001,
    FSPS_PROG = 3'b010,
    FSPS_DONE = 3'b011
  } fsps_state_e;

  // Decoded flash address from the pointer.
  typedef struct packed {
    logic [PAGE_SEL_W-1:0] page_select_field;
    logic [WORD_SEL_W-1:0] word_select_field;
    logic byte_sel;
  } fsps_addr_s;

  // Boot section layout for one fuse setting.
  typedef struct packed {
    logic [PC_W-1:0] boot_start;
    logic [PC_W-1:0] app_end;
  } fsps_boot_s;

endpackage : fsps_pkg

/* File: src/fsps_rc_timer.sv */
// Programming timer counted on ticks of the calibrated RC oscillator.
`timescale 1ns/1ps
`default_nettype none
module fsps_rc_timer
  import fsps_pkg::*;
#(
  parameter int unsigned TICKS = PROG_TICKS_DEF
)
(
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  input wire logic i_rc_clk,
  input wire logic i_start,
  output logic o_done
);

  ////////////////////////////////////////////////////////////////////////
  // The RC clock is foreign, so it passes two flops before edge detection.
  logic rc_s1;
  logic rc_s2;
  logic rc_s3;
  logic [22:0] ticks;
  logic running;
  wire rc_tick = rc_s2 & ~rc_s3;
  wire last_tick = (ticks == 23'(TICKS - 1));

  always_ff @(posedge i_clk_sys or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      rc_s1 <= 1'b0;
      rc_s2 <= 1'b0;
      rc_s3 <= 1'b0;
    end
    else
    begin
      rc_s1 <= i_rc_clk;
      rc_s2 <= rc_s1;
      rc_s3 <= rc_s2;
    end
  end

  // Count RC ticks, not system clocks, so timing tracks the oscillator.
  always_ff @(posedge i_clk_sys or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      ticks <= '0;
      running <= 1'b0;
      o_done <= 1'b0;
    end
    else
    begin
      o_done <= running & rc_tick & last_tick;
      if (i_start)
      begin
        running <= 1'b1;
        ticks <= '0;
      end
      else if (running && rc_tick)
      begin
        running <= ~last_tick;
        ticks <= ticks + 23'h000001;
      end
    end
  end

endmodule : fsps_rc_timer
`default_nettype wire

/* File: testbench/fsps_cpu_model.sv */
// CPU core model that fires the self-program instruction after a command.
`timescale 1ns/1ps
`default_nettype none
module fsps_cpu_model
  import fsps_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  input wire logic i_go,
  input wire logic [3:0] i_gap,
  input wire logic [15:0] i_word,
  output logic o_spm_exec,
  output logic [15:0] o_spm_data
);
  logic [3:0] cnt;
  ////////////////////////////////////////////////////////////////////////////
  // The instruction lands i_gap+1 cycles after the command write; a gap
  // above three is a deliberate late issue. No interrupt path exists here,
  // so the timed write is never split. Data toggles outside the issue.
  always_ff @(posedge i_clk_sys or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      cnt <= 4'h0;
      o_spm_exec <= 1'b0;
      o_spm_data <= 16'hFFFF;
    end
    else
    begin
      o_spm_exec <= (cnt == 4'h1);
      o_spm_data <= (cnt == 4'h1) ? i_word : ~o_spm_data;
      if (i_go)
        cnt <= i_gap;
      else if (cnt != 4'h0)
        cnt <= cnt - 4'h1;
    end
  end
endmodule : fsps_cpu_model
`default_nettype wire

/* File: testbench/fsps_monitor.sv */
// Checker for the sequencer: timing, address map and fetch gating.
`timescale 1ns/1ps
`default_nettype none
module fsps_monitor
  import fsps_pkg::*;
#(
  parameter int unsigned PROG_TICKS = PROG_TICKS_DEF
)
(
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  input wire logic i_boot_size_sel_hi,
  input wire logic i_boot_size_sel_lo,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic [PC_W-1:0] i_fetch_addr,
  input wire logic o_fetch_allow,
  input wire logic o_prog_req,
  input wire logic o_erase_req,
  input wire logic o_write_req,
  input wire logic o_lock_req,
  input wire fsps_addr_s o_flash_addr,
  input wire fsps_boot_s o_boot
);
  // Sync and RC phase add a few cycles either side of the nominal time.
  localparam int LO = PROG_TICKS * 25 / 8 - 4;
  localparam int HI = PROG_TICKS * 25 / 8 + 6;
  logic [31:0] cnt;
  logic [13:0] hptr;
  logic [PC_W-1:0] bst;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rstn);
  ////////////////////////////////////////////////////////////////////////////
  // Boot start from the fuse straps, which only move under reset.
  assign bst = i_boot_size_sel_hi ?
    (i_boot_size_sel_lo ? 13'h1F80 : 13'h1F00) :
    (i_boot_size_sel_lo ? 13'h1E00 : 13'h1C00);
  // Length of the current timed operation, and a shadow of the pointer.
  always_ff @(posedge i_clk_sys or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      cnt <= 32'h0;
      hptr <= 14'h0;
    end
    else
    begin
      cnt <= o_prog_req ? cnt + 32'h1 : 32'h0;
      if (i_wr && i_addr == OFS_PTR_LO)
        hptr[7:0] <= i_wdata;
      if (i_wr && i_addr == OFS_PTR_HI)
        hptr[13:8] <= i_wdata[5:0];
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  boot_map_a: assert property ($past(i_rstn) |->
    o_boot == {bst, bst - 13'h1}) else $error("boot layout wrong");
  addr_map_a: assert property ($past(i_rstn) |->
    o_flash_addr == $past(hptr)) else $error("flash address wrong");
  op_max_a: assert property (o_prog_req |-> cnt < HI)
    else $error("timed operation too long");
  op_min_a: assert property ($past(i_rstn) && $fell(o_prog_req) |->
    cnt >= LO) else $error("timed operation too short");
  enable_hold_a: assert property ($rose(o_prog_req) |->
    o_prog_req [*8]) else $error("enable dropped early");
  prog_cause_a: assert property ($rose(o_prog_req) |->
    o_erase_req || o_write_req || o_lock_req) else $error("no cause");
  write_pulse_a: assert property (o_write_req |=>
    !o_write_req && o_prog_req) else $error("write pulse wrong");
  fetch_block_a: assert property ((o_erase_req || o_write_req) &&
    i_fetch_addr < BLOCKED_FIRST |-> !o_fetch_allow)
    else $error("readable region fetched during op");
  erase_c: cover property (o_erase_req);
  write_c: cover property (o_write_req);
  lock_c: cover property (o_lock_req);
endmodule : fsps_monitor
bind fsps_sequencer fsps_monitor #(.PROG_TICKS(PROG_TICKS)) u_mon (
  .i_clk_sys(i_clk_sys),
  .i_rstn(i_rstn),
  .i_boot_size_sel_hi(i_boot_size_sel_hi),
  .i_boot_size_sel_lo(i_boot_size_sel_lo),
  .i_addr(i_addr),
  .i_wdata(i_wdata),
  .i_wr(i_wr),
  .i_fetch_addr(i_fetch_addr),
  .o_fetch_allow(o_fetch_allow),
  .o_prog_req(o_prog_req),
  .o_erase_req(o_erase_req),
  .o_write_req(o_write_req),
  .o_lock_req(o_lock_req),
  .o_flash_addr(o_flash_addr),
  .o_boot(o_boot)
);
`default_nettype wire

/* File: testbench/tb.sv */
// Testbench for the flash self-programming sequencer.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import fsps_pkg::*;
  logic clk, rstn, rc, hi, lo, ee, wr, rd, exec, go, allow, halt, preq;
  logic erq, wrq, lrq, frq;
  logic [3:0] addr, gap;
  logic [7:0] wdata, rdata, ldat;
  logic [15:0] sdata, word, fdat;
  logic [PC_W-1:0] fetch;
  logic [31:0] v;
  fsps_addr_s fa;
  fsps_boot_s bo;
  int bad_count, tests_run, cyc, n_er, n_wr, n_lk, n_fl;
  logic [12:0] bs [4] = '{13'h1C00, 13'h1E00, 13'h1F00, 13'h1F80};
  fsps_sequencer #(.PROG_TICKS(10)) dut (.i_clk_sys(clk), .i_rstn(rstn),
    .i_rc_clk(rc), .i_boot_size_sel_hi(hi), .i_boot_size_sel_lo(lo),
    .i_eeprom_write_busy_bit(ee), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_spm_exec(exec),
    .i_spm_data(sdata), .i_fetch_addr(fetch), .o_fetch_allow(allow),
    .o_cpu_halt(halt), .o_prog_req(preq), .o_erase_req(erq),
    .o_write_req(wrq), .o_lock_req(lrq), .o_fill_req(frq),
    .o_fill_data(fdat), .o_lock_data(ldat), .o_flash_addr(fa), .o_boot(bo));
  fsps_cpu_model cpu (.i_clk_sys(clk), .i_rstn(rstn), .i_go(go),
    .i_gap(gap), .i_word(word), .o_spm_exec(exec), .o_spm_data(sdata));
  ////////////////////////////////////////////////////////////////////////////
  // System clock at 25 MHz; the RC clock runs unrelated at 8 MHz.
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial
  begin
    rc = 1'b0;
    forever #62.5 rc = ~rc;
  end
  // Pulse counters, plus a ceiling that cuts a hang short.
  always @(posedge clk)
  begin
    n_er += erq;
    n_wr += wrq;
    n_lk += lrq;
    n_fl += frq;
    cyc++;
    if (cyc > 20000)
    begin
      bad_count++;
      report_and_stop();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    if (bad_count == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e)
    begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, s, e);
    end
  endtask : check
  // One-cycle write; g also tells the CPU model to issue after gap cycles.
  // A spare edge follows, so the next strobe is never driven twice at once.
  task automatic wrr(input logic [3:0] a, input logic [7:0] d, input logic g);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    go <= g;
    @(posedge clk);
    wr <= 1'b0;
    go <= 1'b0;
    @(posedge clk);
  endtask : wrr
  // Read data stand only in the cycle after the strobe.
  task automatic rdd(input logic [3:0] a, output logic [31:0] d);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    d = 32'(rdata);
  endtask : rdd
  task automatic set_ptr(input logic [15:0] p);
    wrr(OFS_PTR_LO, p[7:0], 1'b0);
    wrr(OFS_PTR_HI, p[15:8], 1'b0);
  endtask : set_ptr
  // Software must see the enable bit clear before a new command.
  task automatic wait_idle();
    v = 32'h1;
    for (int i = 0; i < 100 && v[0] !== 1'b0; i++)
      rdd(OFS_CTRL, v);
  endtask : wait_idle
  task automatic do_reset(input logic h, input logic l);
    rstn <= 1'b0;
    hi <= h;
    lo <= l;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    repeat (6) @(posedge clk);
  endtask : do_reset
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {rstn, hi, lo, ee, wr, rd, go, addr, wdata} = '0;
    gap = 4'h1;
    word = 16'h0;
    fetch = 13'h0100;
    for (int i = 0; i < 4; i++)
    begin
      do_reset(i[1], i[0]);
      check(bo, {bs[i], bs[i] - 13'h1});
      rdd(OFS_SEL, v);
      check(v, i);
    end
    // Erase a readable page: busy holds until the re-enable command.
    set_ptr(16'h0280);
    wrr(OFS_CTRL, 8'h03, 1'b1);
    repeat (4) @(posedge clk);
    @(negedge clk);
    check({preq, allow}, 2'b10);
    @(posedge clk);
    fetch <= 13'h1C00;
    @(negedge clk);
    check(allow, 1'b1);
    @(posedge clk);
    wrr(OFS_CTRL, 8'h05, 1'b0);
    rdd(OFS_CTRL, v);
    check(v, 32'h43);
    wait_idle();
    rdd(OFS_CTRL, v);
    check(v, 32'h40);
    check(n_er, 32'h1);
    check(fa, {7'h05, 7'h00});
    wrr(OFS_CTRL, 8'h11, 1'b1);
    repeat (4) @(posedge clk);
    rdd(OFS_CTRL, v);
    check(v, 32'h0);
    // Page write to the last blocked page with pointer top bits set.
    fetch <= 13'h0100;
    set_ptr(16'hFF80);
    wrr(OFS_CTRL, 8'h05, 1'b1);
    repeat (4) @(posedge clk);
    @(negedge clk);
    check({halt, preq, fa}, {2'b11, 7'h7F, 7'h0});
    @(posedge clk);
    rdd(OFS_STATUS, v);
    check(v, 32'h3);
    wait_idle();
    rdd(OFS_CTRL, v);
    check(v, 32'h0);
    check(n_wr, 32'h1);
    // Late issue: the command clears itself and nothing starts.
    gap <= 4'h8;
    wrr(OFS_CTRL, 8'h05, 1'b1);
    repeat (12) @(posedge clk);
    rdd(OFS_CTRL, v);
    check(v, 32'h0);
    check(n_wr, 32'h1);
    check(preq, 1'b0);
    // Command writes are dropped while the EEPROM write is busy.
    gap <= 4'h1;
    ee <= 1'b1;
    repeat (4) @(posedge clk);
    wrr(OFS_CTRL, 8'h03, 1'b1);
    repeat (4) @(posedge clk);
    rdd(OFS_CTRL, v);
    check(v, 32'h0);
    check(n_er, 32'h1);
    rdd(OFS_STATUS, v);
    check(v, 32'h4);
    ee <= 1'b0;
    repeat (4) @(posedge clk);
    // Byte select on a load pointer, then a fill with pointer bit 0 clear.
    set_ptr(16'h0043);
    @(negedge clk);
    check(fa, 32'h0043);
    @(posedge clk);
    set_ptr(16'h0042);
    word <= 16'hA55A;
    wrr(OFS_CTRL, 8'h01, 1'b1);
    repeat (4) @(posedge clk);
    @(negedge clk);
    check(n_fl, 32'h1);
    check(fdat, 16'hA55A);
    check(fa, {7'h00, 7'h42});
    // Lock write keeps the whole flash readable.
    @(posedge clk);
    word <= 16'h00C3;
    wrr(OFS_CTRL, 8'h09, 1'b1);
    repeat (4) @(posedge clk);
    @(negedge clk);
    check({preq, allow, ldat}, {2'b11, 8'hC3});
    @(posedge clk);
    wait_idle();
    rdd(OFS_CTRL, v);
    check(v, 32'h0);
    check(n_lk, 32'h1);
    rdd(4'hF, v);
    check(v, 32'h0);
    report_and_stop();
  end
endmodule : tb
`default_nettype wire
